// File: logic/npic_pkg.sv
package npic_pkg;
  // ==========================================================
  // Vector set
  localparam int NPIC_NVEC = 14;
  localparam int NPIC_NEXT = 4;
  localparam int NPIC_NPER = 10;
  localparam int NPIC_PINS = 4;
  localparam logic [15:0] NPIC_VEC_RST = 16'hFFFE;
  localparam logic [15:0] NPIC_VEC_TRAP = 16'hFFFC;
  localparam logic [15:0] NPIC_VEC_TOP = 16'hFFFA;
  // Vectors allowed to end Halt: all external lines plus two peripherals
  localparam logic [13:0] NPIC_HALT_WAKE = 14'h003F;

  // ==========================================================
  // Level codes and condition code layout
  localparam logic [1:0] NPIC_LVL0 = 2'h2;
  localparam logic [1:0] NPIC_LVL1 = 2'h1;
  localparam logic [1:0] NPIC_LVL2 = 2'h0;
  localparam logic [1:0] NPIC_LVL3 = 2'h3;
  localparam int NPIC_CC_LVL_HI = 5;
  localparam int NPIC_CC_LVL_LO = 3;
  localparam logic [7:0] NPIC_CC_RST = 8'hEA;
  localparam logic [7:0] NPIC_PRIO_RST = 8'hFF;
  localparam logic [3:0] NPIC_PRIO3_RO = 4'hF;

  // ==========================================================
  // Register map (byte addresses on the bus)
  localparam logic [7:0] NPIC_OFS_PRIO0 = 8'h00;
  localparam logic [7:0] NPIC_OFS_PRIO1 = 8'h04;
  localparam logic [7:0] NPIC_OFS_PRIO2 = 8'h08;
  localparam logic [7:0] NPIC_OFS_PRIO3 = 8'h0C;
  localparam logic [7:0] NPIC_OFS_CC = 8'h10;
  localparam logic [7:0] NPIC_OFS_PEND = 8'h14;
  localparam logic [7:0] NPIC_OFS_PINEN = 8'h18;
  localparam logic [15:0] NPIC_PINEN_RST = 16'h0000;

  // ==========================================================
  // Sequencer operation codes, given with each instruction end
  typedef enum logic [2:0] {
    NPIC_OP_NONE = 3'h0,
    NPIC_OP_UNMASK = 3'h1,
    NPIC_OP_MASK = 3'h2,
    NPIC_OP_HALT = 3'h3,
    NPIC_OP_WAIT = 3'h4,
    NPIC_OP_RETURN = 3'h5,
    NPIC_OP_POPCC = 3'h6,
    NPIC_OP_TRAP = 3'h7
  } npic_op_t;

  // Service sequence, Gray coded along the path
  typedef enum logic [1:0] {
    NPIC_ST_IDLE = 2'h0,
    NPIC_ST_STACK = 2'h1,
    NPIC_ST_LOAD = 2'h3,
    NPIC_ST_FETCH = 2'h2
  } npic_state_t;

  // Arbitration result
  typedef struct packed {
    logic hit;
    logic [3:0] idx;
  } npic_pick_t;
endpackage

// File: logic/npic_ctrl.sv
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
// What this block does
// - Level codes: 0=10, 1=01, 2=00, 3=11
// - Level bits at condition code bits 5, 3
// - Sixteen fixed vectors from FFE0h to FFFFh
// - Service starts at an instruction end, or at once in Halt, in Wait or for reset
// - Maskable and trap entries stack the context
// - Maskable entry loads the vector's stored priority
// - Vector address loaded, then first handler fetch
// - Return pops condition codes, restoring the level
// - Highest software priority wins, hardware breaks ties
// - Unserviced requests stay latched as pending
// - Reset and trap preempt even level 3
// - Non-maskable: no mask, level 3, reset unstacked
// - Non-maskable sources also end Halt
// - Trap instruction raises trap service
// - Maskable needs enable and strictly higher priority
// - Edge latch cleared on handler entry
// - Pins sharing a line are ORed
// - Peripheral request is flag AND enable
// - Clear sequence drops the peripheral latch
// - Any request ends Wait, designated ones Halt
// - Leaving Halt serves highest wake-capable first
// - Instructions also write the level bits
// - Priorities reset to ones; level 0 writes ignored
// - Four priority registers, top bits read one
module npic_ctrl
  import npic_pkg::*;
(
  // Clock, reset, enable
  input wire logic MCLK_I,
  input wire logic RESET_I,
  input wire logic CE_I,
  // Wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [7:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O,
  // Interrupt sources
  input wire logic [15:0] EXT_PIN_I,
  input wire logic [9:0] PERIPH_FLAG_I,
  input wire logic [9:0] PERIPH_EN_I,
  input wire logic [9:0] PERIPH_CLR_I,
  // CPU sequencer
  input wire logic INSTR_END_I,
  input wire logic [2:0] OP_I,
  input wire logic [7:0] CC_POP_I,
  input wire logic STACK_DONE_I,
  output logic PUSH_CTX_O,
  output logic LOAD_PC_O,
  output logic FETCH_O,
  output logic [15:0] VEC_ADDR_O,
  output logic [7:0] CC_O,
  output logic HALT_O,
  output logic WAIT_O
);
  // ==========================================================
  // Helpers
  function automatic logic [1:0] npic_rank(input logic [1:0] code);
    logic [1:0] r;
    case (code)
      NPIC_LVL0: r = 2'h0;
      NPIC_LVL1: r = 2'h1;
      NPIC_LVL2: r = 2'h2;
      default: r = 2'h3;
    endcase
    return r;
  endfunction

  // Scan downward so that the lower index, the higher hardware priority, wins ties
  function automatic npic_pick_t npic_arb(input logic [13:0] req, input logic [27:0] pri,
                                          input logic [1:0] cur);
    npic_pick_t p;
    logic [1:0] best;
    logic [1:0] r;
    p = '0;
    best = 2'h0;
    r = 2'h0;
    for (int i = NPIC_NVEC - 1; i >= 0; i--) begin
      r = npic_rank(pri[2*i +: 2]);
      if (req[i] && (r > npic_rank(cur)) && (!p.hit || (r >= best))) begin
        p.hit = 1'b1;
        best = r;
        p.idx = 4'(i);
      end
    end
    return p;
  endfunction

  function automatic logic [15:0] npic_vaddr(input logic [3:0] idx);
    return NPIC_VEC_TOP - {11'h000, idx, 1'b0};
  endfunction

  // ==========================================================
  // State
  npic_state_t state_q;
  logic [7:0] cc_q;
  logic [27:0] prio_q;
  logic [15:0] pinen_q;
  logic [3:0] ext_prev_q;
  logic [3:0] ext_pend_q;
  logic [9:0] per_pend_q;
  logic rst_pend_q;
  logic halt_q;
  logic wait_q;
  logic svc_mask_q;
  logic [3:0] svc_idx_q;
  logic [1:0] svc_lvl_q;
  logic [15:0] vec_q;
  logic ack_q;
  logic [31:0] dat_q;

  logic [1:0] cur_lvl;
  logic [3:0] ext_line;
  logic [3:0] ext_rise;
  logic [9:0] per_req;
  logic [13:0] pend;
  logic [13:0] req;
  npic_pick_t pick;
  npic_op_t op;
  logic boundary;
  logic take_rst;
  logic take_trap;
  logic take_irq;
  logic take;
  logic wb_req;
  logic wb_wr;
  logic [7:0] wb_ofs;

  assign op = npic_op_t'(OP_I);
  assign cur_lvl = {cc_q[NPIC_CC_LVL_HI], cc_q[NPIC_CC_LVL_LO]};

  // ==========================================================
  // Source conditioning
  always_comb begin
    for (int g = 0; g < NPIC_NEXT; g++) begin
      ext_line[g] = |(EXT_PIN_I[NPIC_PINS*g +: NPIC_PINS] & pinen_q[NPIC_PINS*g +: NPIC_PINS]);
    end
  end
  assign ext_rise = ext_line & ~ext_prev_q;
  assign per_req = PERIPH_FLAG_I & PERIPH_EN_I;
  assign pend = {per_pend_q, ext_pend_q};

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      ext_prev_q <= '0;
    end else if (CE_I) begin
      ext_prev_q <= ext_line;
    end
  end

  // Edge latch: a new edge in the entry cycle survives the entry clear
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      ext_pend_q <= '0;
    end else if (CE_I) begin
      for (int g = 0; g < NPIC_NEXT; g++) begin
        if (ext_rise[g]) begin
          ext_pend_q[g] <= 1'b1;
        end else if (state_q == NPIC_ST_LOAD && svc_mask_q && svc_idx_q == 4'(g)) begin
          ext_pend_q[g] <= 1'b0;
        end
      end
    end
  end

  // The clear sequence wins here on purpose: a request caught during it is lost
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      per_pend_q <= '0;
    end else if (CE_I) begin
      per_pend_q <= (per_pend_q | per_req) & ~PERIPH_CLR_I;
    end
  end

  // ==========================================================
  // Arbitration, evaluated every clock
  // While halted only wake-capable vectors compete, so one of them is served first
  assign req = halt_q ? (pend & NPIC_HALT_WAKE) : pend;
  assign pick = npic_arb(req, prio_q, cur_lvl);
  assign boundary = (state_q == NPIC_ST_IDLE) && INSTR_END_I;
  assign take_rst = (state_q == NPIC_ST_IDLE) && rst_pend_q;
  assign take_trap = boundary && !rst_pend_q && op == NPIC_OP_TRAP;
  assign take_irq = (state_q == NPIC_ST_IDLE) && !rst_pend_q && !take_trap && pick.hit &&
                    (INSTR_END_I || halt_q || wait_q);
  assign take = take_rst || take_trap || take_irq;

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      rst_pend_q <= 1'b1;
    end else if (CE_I && take_rst) begin
      rst_pend_q <= 1'b0;
    end
  end

  // ==========================================================
  // Service sequence
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      state_q <= NPIC_ST_IDLE;
    end else if (CE_I) begin
      case (state_q)
        NPIC_ST_IDLE: begin
          if (take_rst) begin
            state_q <= NPIC_ST_LOAD;
          end else if (take) begin
            state_q <= NPIC_ST_STACK;
          end
        end
        NPIC_ST_STACK: begin
          if (STACK_DONE_I) begin
            state_q <= NPIC_ST_LOAD;
          end
        end
        NPIC_ST_LOAD: begin
          state_q <= NPIC_ST_FETCH;
        end
        NPIC_ST_FETCH: begin
          state_q <= NPIC_ST_IDLE;
        end
        default: begin
          state_q <= NPIC_ST_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      svc_mask_q <= 1'b0;
      svc_idx_q <= '0;
      svc_lvl_q <= NPIC_LVL3;
      vec_q <= NPIC_VEC_RST;
    end else if (CE_I && take) begin
      svc_mask_q <= take_irq;
      svc_idx_q <= pick.idx;
      if (take_rst) begin
        vec_q <= NPIC_VEC_RST;
        svc_lvl_q <= NPIC_LVL3;
      end else if (take_trap) begin
        vec_q <= NPIC_VEC_TRAP;
        svc_lvl_q <= NPIC_LVL3;
      end else begin
        vec_q <= npic_vaddr(pick.idx);
        svc_lvl_q <= prio_q[2*pick.idx +: 2];
      end
    end
  end

  // Trap and reset end Halt by being taken in any state of the sleep flags
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      halt_q <= 1'b0;
      wait_q <= 1'b0;
    end else if (CE_I) begin
      if (take) begin
        halt_q <= 1'b0;
        wait_q <= 1'b0;
      end else if (boundary && op == NPIC_OP_HALT) begin
        halt_q <= 1'b1;
      end else if (boundary && op == NPIC_OP_WAIT) begin
        wait_q <= 1'b1;
      end
    end
  end

  // ==========================================================
  // Condition code register
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      cc_q <= NPIC_CC_RST;
    end else if (CE_I) begin
      if (state_q == NPIC_ST_LOAD) begin
        {cc_q[NPIC_CC_LVL_HI], cc_q[NPIC_CC_LVL_LO]} <= svc_lvl_q;
      end else if (boundary && !take) begin
        case (op)
          NPIC_OP_UNMASK, NPIC_OP_HALT, NPIC_OP_WAIT: begin
            {cc_q[NPIC_CC_LVL_HI], cc_q[NPIC_CC_LVL_LO]} <= NPIC_LVL0;
          end
          NPIC_OP_MASK: begin
            {cc_q[NPIC_CC_LVL_HI], cc_q[NPIC_CC_LVL_LO]} <= NPIC_LVL3;
          end
          NPIC_OP_RETURN, NPIC_OP_POPCC: begin
            cc_q <= CC_POP_I;
          end
          default: begin
            cc_q <= cc_q;
          end
        endcase
      end
    end
  end

  // ==========================================================
  // Wishbone registers
  assign wb_req = WB_CYC_I && WB_STB_I && !ack_q;
  assign wb_wr = wb_req && WB_WE_I && WB_SEL_I[0];
  assign wb_ofs = {WB_ADR_I[7:2], 2'b00};

  // A field written with the level 0 code keeps its old value
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      prio_q <= {NPIC_PRIO_RST[3:0], {3{NPIC_PRIO_RST}}};
      pinen_q <= NPIC_PINEN_RST;
    end else if (CE_I && wb_wr) begin
      for (int f = 0; f < NPIC_NVEC; f++) begin
        if (wb_ofs == NPIC_OFS_PRIO0 + 8'(4 * (f / 4)) &&
            WB_DAT_I[2*(f%4) +: 2] != NPIC_LVL0) begin
          prio_q[2*f +: 2] <= WB_DAT_I[2*(f%4) +: 2];
        end
      end
      if (wb_ofs == NPIC_OFS_PINEN) begin
        pinen_q[7:0] <= WB_DAT_I[7:0];
        if (WB_SEL_I[1]) begin
          pinen_q[15:8] <= WB_DAT_I[15:8];
        end
      end
    end
  end

  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      ack_q <= 1'b0;
      dat_q <= '0;
    end else if (CE_I) begin
      ack_q <= wb_req;
      if (wb_req) begin
        case (wb_ofs)
          NPIC_OFS_PRIO0: dat_q <= {24'h000000, prio_q[7:0]};
          NPIC_OFS_PRIO1: dat_q <= {24'h000000, prio_q[15:8]};
          NPIC_OFS_PRIO2: dat_q <= {24'h000000, prio_q[23:16]};
          NPIC_OFS_PRIO3: dat_q <= {24'h000000, NPIC_PRIO3_RO, prio_q[27:24]};
          NPIC_OFS_CC: dat_q <= {24'h000000, cc_q};
          NPIC_OFS_PEND: dat_q <= {18'h00000, pend};
          NPIC_OFS_PINEN: dat_q <= {16'h0000, pinen_q};
          default: dat_q <= '0;
        endcase
      end
    end
  end

  // ==========================================================
  // Outputs
  assign WB_ACK_O = ack_q;
  assign WB_DAT_O = dat_q;
  assign PUSH_CTX_O = (state_q == NPIC_ST_STACK);
  assign LOAD_PC_O = (state_q == NPIC_ST_LOAD);
  assign FETCH_O = (state_q == NPIC_ST_FETCH);
  assign VEC_ADDR_O = vec_q;
  assign CC_O = cc_q;
  assign HALT_O = halt_q;
  assign WAIT_O = wait_q;

  // ==========================================================
  // Checks
  a_level_on_entry: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (LOAD_PC_O && CE_I && svc_mask_q) |=> (cur_lvl == $past(prio_q[2*svc_idx_q +: 2])))
    else $error("entry level differs from stored priority");
  a_nmi_level_three: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (LOAD_PC_O && CE_I && !svc_mask_q) |=> (cur_lvl == NPIC_LVL3))
    else $error("non-maskable entry did not set level 3");
  a_vector_address: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (LOAD_PC_O && svc_mask_q) |-> (VEC_ADDR_O == NPIC_VEC_TOP - {11'h000, svc_idx_q, 1'b0}))
    else $error("wrong vector address");
  a_reset_no_stack: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (take_rst && CE_I) |=> (LOAD_PC_O && VEC_ADDR_O == NPIC_VEC_RST && !PUSH_CTX_O))
    else $error("reset entry stacked or missed its vector");
  a_mask_gate: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    take_irq |-> (npic_rank(prio_q[2*pick.idx +: 2]) > npic_rank(cur_lvl) && pend[pick.idx]))
    else $error("request taken without higher priority");
  a_halt_wake_first: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (take_irq && halt_q) |-> NPIC_HALT_WAKE[pick.idx])
    else $error("halt left by a non-waking vector");
  a_trap_entry: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (take_trap && CE_I) |=> (PUSH_CTX_O && vec_q == NPIC_VEC_TRAP))
    else $error("trap did not enter with stacking");
  a_level0_kept: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (CE_I && wb_wr && wb_ofs == NPIC_OFS_PRIO0 && WB_DAT_I[1:0] == NPIC_LVL0)
      |=> (prio_q[1:0] == $past(prio_q[1:0])))
    else $error("level 0 write altered a priority");
  a_stack_then_load: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (PUSH_CTX_O && STACK_DONE_I && CE_I) |=> (LOAD_PC_O ##1 FETCH_O))
    else $error("entry sequence broken after stacking");
  a_return_level: assert property (@(posedge MCLK_I) disable iff (RESET_I)
    (boundary && CE_I && !take && op == NPIC_OP_RETURN) |=> (cc_q == $past(CC_POP_I)))
    else $error("return did not restore condition codes");

  c_reset_entry: cover property (@(posedge MCLK_I) take_rst ##1 LOAD_PC_O);
  c_trap_entry: cover property (@(posedge MCLK_I) take_trap);
  c_nested_entry: cover property (@(posedge MCLK_I) take_irq && cur_lvl != NPIC_LVL0);
  c_halt_wake: cover property (@(posedge MCLK_I) take_irq && halt_q);
endmodule

// File: test/npic_seq_model.sv
`timescale 1ns/10ps
module npic_seq_model
  import npic_pkg::*;
(
  // Clock and reset
  input wire logic MCLK_I,
  input wire logic RESET_I,
  // Controller side
  input wire logic PUSH_CTX_I,
  input wire logic INSTR_END_I,
  input wire logic [2:0] OP_I,
  input wire logic [7:0] CC_I,
  // Bench control
  input wire logic [1:0] DELAY_I,
  output logic STACK_DONE_O,
  output logic [7:0] CC_TOP_O
);
  logic [1:0] wait_q;
  logic [7:0] stack_q [8];
  logic [2:0] sp_q;

  // ==========================================================
  // Context push
  // Slow stack memory: DELAY_I extra cycles before the push completes
  assign STACK_DONE_O = PUSH_CTX_I && (wait_q == DELAY_I);
  assign CC_TOP_O = stack_q[sp_q - 3'h1];

  always_ff @(posedge MCLK_I) begin
    if (RESET_I || !PUSH_CTX_I) begin
      wait_q <= 2'h0;
    end else if (!STACK_DONE_O) begin
      wait_q <= wait_q + 2'h1;
    end
  end

  // ==========================================================
  // Saved condition codes, popped again by a return
  always_ff @(posedge MCLK_I) begin
    if (RESET_I) begin
      sp_q <= 3'h0;
    end else if (STACK_DONE_O) begin
      stack_q[sp_q] <= CC_I;
      sp_q <= sp_q + 3'h1;
    end else if (INSTR_END_I && OP_I == NPIC_OP_RETURN) begin
      sp_q <= sp_q - 3'h1;
    end
  end
endmodule

// File: test/npic_ctrl_tb.sv
`timescale 1ns/10ps
`define CHK(nm, ex, got) begin samples_checked++; if ((got) !== (ex)) begin num_errors++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, ex, got); end end
module npic_ctrl_tb
  import npic_pkg::*;
;
  logic mclk = 1'b0;
  logic reset = 1'b1;
  logic cyc, stb, we, iend;
  logic [7:0] adr, pop, cc, top;
  logic [31:0] wdat, rdat;
  logic [15:0] pins, vec;
  logic [9:0] flag, en, clr;
  logic [1:0] dly;
  npic_op_t op;
  logic ack, push, load, fetch, halt, wt, done;
  logic [1:0] pr [14];
  logic [31:0] seed = 32'h00014E77;
  int num_errors = 0;
  int samples_checked = 0;
  wire logic [1:0] lvl = {cc[NPIC_CC_LVL_HI], cc[NPIC_CC_LVL_LO]};

  always #50 mclk = ~mclk;

  npic_ctrl i_npic_ctrl (
    .MCLK_I(mclk),
    .RESET_I(reset),
    .CE_I(1'b1),
    .WB_CYC_I(cyc),
    .WB_STB_I(stb),
    .WB_WE_I(we),
    .WB_ADR_I(adr),
    .WB_SEL_I(4'hF),
    .WB_DAT_I(wdat),
    .WB_DAT_O(rdat),
    .WB_ACK_O(ack),
    .EXT_PIN_I(pins),
    .PERIPH_FLAG_I(flag),
    .PERIPH_EN_I(en),
    .PERIPH_CLR_I(clr),
    .INSTR_END_I(iend),
    .OP_I(op),
    .CC_POP_I(pop),
    .STACK_DONE_I(done),
    .PUSH_CTX_O(push),
    .LOAD_PC_O(load),
    .FETCH_O(fetch),
    .VEC_ADDR_O(vec),
    .CC_O(cc),
    .HALT_O(halt),
    .WAIT_O(wt)
  );

  npic_seq_model i_npic_seq_model (
    .MCLK_I(mclk),
    .RESET_I(reset),
    .PUSH_CTX_I(push),
    .INSTR_END_I(iend),
    .OP_I(op),
    .CC_I(cc),
    .DELAY_I(dly),
    .STACK_DONE_O(done),
    .CC_TOP_O(top)
  );

  // ==========================================================
  // Expectation helpers
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic int rk(logic [1:0] l);
    return (l == NPIC_LVL0) ? 0 : (l == NPIC_LVL1) ? 1 : (l == NPIC_LVL2) ? 2 : 3;
  endfunction

  // Walks downwards so equal ranks settle on the lowest vector
  function automatic int win(logic [13:0] p, logic [1:0] l);
    int w = -1;
    for (int i = 13; i >= 0; i--) begin
      if (p[i] && rk(pr[i]) > rk(l) && (w < 0 || rk(pr[i]) >= rk(pr[w]))) begin
        w = i;
      end
    end
    return w;
  endfunction

  // ==========================================================
  // Drivers
  task automatic finish_test();
    $display("checks %0d mismatches %0d", samples_checked, num_errors);
    if (num_errors == 0 && samples_checked > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic tmo(input int n);
    if (n >= 30) begin
      num_errors++;
      $display("CHECK FAILED handshake expected 1 seen 0");
      finish_test();
    end
  endtask

  task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d,
                    output logic [31:0] r);
    int n = 0;
    @(posedge mclk);
    cyc <= 1'b1;
    stb <= 1'b1;
    we <= w;
    adr <= a;
    wdat <= d;
    do begin
      @(posedge mclk);
      n++;
    end while (ack !== 1'b1 && n < 30);
    tmo(n);
    r = rdat;
    cyc <= 1'b0;
    stb <= 1'b0;
  endtask

  task automatic wprio(input int n, input logic [7:0] d);
    logic [31:0] r;
    for (int f = 0; f < 4; f++) begin
      if (4 * n + f < 14 && d[2 * f +: 2] != NPIC_LVL0) begin
        pr[4 * n + f] = d[2 * f +: 2];
      end
    end
    wb(1'b1, 8'(4 * n), {24'h0, d}, r);
  endtask

  task automatic step(input npic_op_t o, input logic [7:0] c);
    @(posedge mclk);
    iend <= 1'b1;
    op <= o;
    // A return pops what the model holds at this edge, not at the call
    pop <= (o == NPIC_OP_RETURN) ? top : c;
    @(posedge mclk);
    iend <= 1'b0;
  endtask

  task automatic serve(input logic p, input logic [15:0] v, input logic [1:0] l);
    logic seen = 1'b0;
    int n = 0;
    do begin
      @(posedge mclk);
      seen = seen | push;
      n++;
    end while (load !== 1'b1 && n < 30);
    tmo(n);
    `CHK("stacking", p, seen)
    `CHK("vector", v, vec)
    @(posedge mclk);
    `CHK("fetch", 1'b1, fetch)
    `CHK("entry level", l, lvl)
  endtask

  task automatic quiet(input int c);
    repeat (c) begin
      @(posedge mclk);
      `CHK("no service", 1'b0, push | load)
    end
  endtask

  task automatic clrall();
    @(posedge mclk);
    flag <= 10'h000;
    clr <= 10'h3FF;
    @(posedge mclk);
    clr <= 10'h000;
  endtask

  // ==========================================================
  // Scenarios
  initial begin
    logic [31:0] r;
    logic [13:0] pend;
    int w;
    {cyc, stb, we, iend} <= 4'h0;
    {adr, pop, wdat, pins} <= '0;
    {flag, en, clr, dly} <= '0;
    op <= NPIC_OP_NONE;
    for (int i = 0; i < 14; i++) begin
      pr[i] = NPIC_LVL3;
    end
    repeat (2) @(posedge mclk);
    reset <= 1'b0;
    serve(1'b0, NPIC_VEC_RST, NPIC_LVL3);
    `CHK("cc reset", NPIC_CC_RST, cc)
    for (int i = 0; i < 4; i++) begin
      wb(1'b0, 8'(4 * i), 32'h0, r);
      `CHK("prio reset", 32'h000000FF, r)
    end
    wb(1'b1, 8'h1C, 32'hFFFFFFFF, r);
    wb(1'b0, 8'h1C, 32'h0, r);
    `CHK("unmapped", 32'h00000000, r)
    wprio(3, 8'h00);
    wb(1'b0, NPIC_OFS_PRIO3, 32'h0, r);
    `CHK("prio3 top", 32'h000000F0, r)
    wprio(0, 8'hCF);
    wprio(0, 8'h64);
    wb(1'b0, NPIC_OFS_PRIO0, 32'h0, r);
    `CHK("level 0 write", 32'h00000044, r)
    $display("test registers done");

    step(NPIC_OP_UNMASK, 8'h00);
    repeat (8) begin
      for (int i = 0; i < 4; i++) begin
        wprio(i, 8'(rnd()));
      end
      r = rnd();
      w = r[31:20] % 10;
      pend = {(r[9:0] | 10'(1 << w)) & (r[19:10] | 10'(1 << w)), 4'h0};
      flag <= r[9:0] | 10'(1 << w);
      en <= r[19:10] | 10'(1 << w);
      dly <= r[21:20];
      w = win(pend, NPIC_LVL0);
      step(NPIC_OP_NONE, 8'h00);
      serve(1'b1, NPIC_VEC_TOP - 16'(2 * w), pr[w]);
      clrall();
      step(NPIC_OP_RETURN, top);
      @(posedge mclk);
      `CHK("level restored", NPIC_LVL0, lvl)
    end
    $display("test arbitration done");

    wprio(1, 8'hFD);
    step(NPIC_OP_POPCC, 8'hC2);
    flag <= 10'h001;
    en <= 10'h001;
    step(NPIC_OP_NONE, 8'h00);
    quiet(4);
    wb(1'b0, NPIC_OFS_PEND, 32'h0, r);
    `CHK("held pending", 1'b1, r[4])
    step(NPIC_OP_POPCC, 8'hE2);
    step(NPIC_OP_NONE, 8'h00);
    serve(1'b1, 16'hFFF2, NPIC_LVL1);
    clrall();
    step(NPIC_OP_RETURN, top);
    $display("test masking done");

    step(NPIC_OP_MASK, 8'h00);
    flag <= 10'h002;
    en <= 10'h002;
    step(NPIC_OP_NONE, 8'h00);
    quiet(3);
    step(NPIC_OP_TRAP, 8'h00);
    serve(1'b1, NPIC_VEC_TRAP, NPIC_LVL3);
    clrall();
    wb(1'b0, NPIC_OFS_PEND, 32'h0, r);
    `CHK("pending dropped", 1'b0, r[5])
    step(NPIC_OP_RETURN, top);
    $display("test trap done");

    wb(1'b1, NPIC_OFS_PINEN, 32'h000000F0, r);
    pins <= 16'h0040;
    wb(1'b0, NPIC_OFS_PEND, 32'h0, r);
    `CHK("pin latch", 1'b1, r[1])
    step(NPIC_OP_UNMASK, 8'h00);
    step(NPIC_OP_NONE, 8'h00);
    serve(1'b1, 16'hFFF8, pr[1]);
    wb(1'b0, NPIC_OFS_PEND, 32'h0, r);
    `CHK("edge cleared", 1'b0, r[1])
    step(NPIC_OP_RETURN, top);
    $display("test external done");

    wprio(1, 8'hF7);
    wprio(2, 8'hFF);
    step(NPIC_OP_HALT, 8'h00);
    @(posedge mclk);
    `CHK("halt", 1'b1, halt)
    flag <= 10'h022;
    en <= 10'h020;
    quiet(4);
    en <= 10'h022;
    serve(1'b1, 16'hFFF0, NPIC_LVL1);
    `CHK("halt left", 1'b0, halt)
    step(NPIC_OP_NONE, 8'h00);
    serve(1'b1, 16'hFFE8, NPIC_LVL3);
    clrall();
    step(NPIC_OP_RETURN, top);
    step(NPIC_OP_RETURN, top);
    @(posedge mclk);
    `CHK("nested return", NPIC_LVL0, lvl)
    $display("test halt done");

    step(NPIC_OP_WAIT, 8'h00);
    @(posedge mclk);
    `CHK("wait", 1'b1, wt)
    flag <= 10'h004;
    en <= 10'h004;
    serve(1'b1, 16'hFFEE, pr[6]);
    `CHK("wait left", 1'b0, wt)
    clrall();
    step(NPIC_OP_RETURN, top);
    @(posedge mclk);
    `CHK("wait return", NPIC_LVL0, lvl)
    $display("test wait done");
    finish_test();
  end

  initial begin
    repeat (20000) @(posedge mclk);
    num_errors++;
    $display("CHECK FAILED run length expected end seen limit");
    finish_test();
  end
endmodule
